// ---- logic/fps_pkg.sv ----
package fps_pkg;
  // Parameter block addresses in SRAM page 0
  localparam logic [7:0] FPS_ADDR_FIRST_KEY_SLOT = 8'hf8;
  localparam logic [7:0] FPS_ADDR_SECOND_KEY_SLOT = 8'hf9;
  localparam logic [7:0] FPS_ADDR_BLKID = 8'hfa;
  localparam logic [7:0] FPS_ADDR_CLOCK = 8'hfc;
  localparam logic [7:0] FPS_ADDR_DELAY = 8'hfe;
  localparam logic [7:0] FPS_ADDR_PROT_SRC = 8'h80;
  localparam logic [7:0] FPS_FIRST_KEY_SLOT_VALUE = 8'h3a;
  localparam logic [7:0] FPS_RC_OK = 8'h00;
  localparam logic [7:0] FPS_RC_PROTECTED = 8'h01;
  // Geometry
  localparam int FPS_PROT_BYTES = 64;
  localparam int FPS_MACROS = 2;
  localparam logic [5:0] FPS_PROT_LAST = 6'h3f;
  localparam logic [5:0] FPS_TBL_LAST = 6'h07;
  localparam logic [2:0] FPS_TBL_ID = 3'h0;
  localparam logic [2:0] FPS_TBL_TRIM = 3'h1;
  // Arbitrary neutral die revision value
  localparam logic [15:0] FPS_DIE_REV = 16'h0001;
  localparam logic [7:0] FPS_TRIM_X = 8'hff;

  typedef enum logic [1:0] {
    FPS_LVL_OPEN,
    FPS_LVL_RDPROT,
    FPS_LVL_NOEXTWR,
    FPS_LVL_FULL
  } fps_level_t;

  typedef enum logic [2:0] {
    FPS_FN_NONE,
    FPS_FN_PROTECT,
    FPS_FN_ERASE_ALL,
    FPS_FN_TABLE_READ,
    FPS_FN_CHECK_READ,
    FPS_FN_CHECK_WRITE
  } fps_func_t;

  typedef struct packed {
    logic supervisor_read_allowed;
    logic external_read_allowed;
    logic external_write_allowed;
    logic internal_write_allowed;
  } fps_perm_t;

  // Flash macro command toward the array
  typedef struct packed {
    logic valid;
    logic [1:0] op;
    logic [0:0] macro;
    logic prot_blk;
    logic [7:0] divider;
    logic [7:0] delay;
  } fps_flash_cmd_t;

  localparam logic [1:0] FPS_OP_ERASE = 2'h0;
  localparam logic [1:0] FPS_OP_ZERO = 2'h1;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } fps_sram_wr_t;
endpackage

// ---- logic/fps_supervisor.sv ----
`timescale 1ns/1ps
module fps_supervisor
  import fps_pkg::*;
(
  input wire logic clk_i, // 50 MHz clock
  input wire logic rst_i, // Sync reset, active high
  input wire logic start_i, // Call pulse
  input wire fps_func_t func_i, // Requested function
  input wire logic [7:0] first_key_slot_i, // Key slot one contents
  input wire logic [7:0] second_key_slot_i, // Key slot two contents
  input wire logic [7:0] stack_ptr_i, // Current stack pointer
  input wire logic [7:0] block_number_param_i, // Block or table number
  input wire logic [7:0] divider_i, // Write pulse divider
  input wire logic [7:0] delay_i, // Delay parameter
  input wire logic [7:0] sram_rdata_i, // SRAM byte at sram_raddr_o
  input wire logic flash_done_i, // Flash macro op finished
  input wire logic [7:0] table_rdata_i, // Table row byte at table_addr_o
  input wire logic [7:0] trim_rev_i, // Internal revision count
  output fps_sram_wr_t sram_wr_o, // SRAM write
  output logic [7:0] sram_raddr_o, // SRAM read address
  output fps_flash_cmd_t flash_cmd_o, // Flash macro command
  output logic [5:0] table_addr_o, // Table row byte address
  output logic [7:0] acc_o, // Returned accumulator
  output logic [7:0] idx_o, // Returned index register
  output fps_perm_t perm_o, // Permissions of checked block
  output logic busy_o, // Function running
  output logic done_o, // One-cycle completion pulse
  output logic halt_o // Bad key halt
);
  typedef enum logic [3:0] {
    S_IDLE, S_PROT_RD, S_PROT_WR, S_EA_USER, S_EA_PROT, S_EA_WAIT,
    S_TBL, S_CHECK, S_FINISH, S_HALT
  } fps_state_t;

  // Protection table, one 64-byte bank per macro
  logic [7:0] prot_q [FPS_MACROS*FPS_PROT_BYTES];
  logic [7:0] prot_d [FPS_MACROS*FPS_PROT_BYTES];
  fps_state_t st_q, st_d, ret_q, ret_d;
  fps_func_t fn_q, fn_d;
  logic [6:0] idx_q, idx_d;
  logic [1:0] step_q, step_d;
  logic [0:0] mac_q, mac_d;
  fps_sram_wr_t wr_q, wr_d;
  fps_flash_cmd_t cmd_q, cmd_d;
  logic [7:0] sraddr_q, sraddr_d, acc_q, acc_d, x_q, x_d;
  logic [5:0] taddr_q, taddr_d;
  fps_perm_t perm_q, perm_d;
  logic busy_q, busy_d, done_q, done_d, halt_q, halt_d;

  function automatic fps_perm_t level_perm(input logic [1:0] lvl);
    fps_perm_t p;
    p = '{1'b1, 1'b1, 1'b1, 1'b1};
    unique case (fps_level_t'(lvl))
      FPS_LVL_OPEN: p = '{1'b1, 1'b1, 1'b1, 1'b1};
      FPS_LVL_RDPROT: p = '{1'b0, 1'b0, 1'b1, 1'b1};
      FPS_LVL_NOEXTWR: p = '{1'b0, 1'b0, 1'b0, 1'b1};
      FPS_LVL_FULL: p = '{1'b0, 1'b0, 1'b0, 1'b0};
    endcase
    return p;
  endfunction

  // Block b lives in byte b/4, bits 2*(b%4) upward
  function automatic logic [1:0] block_level(input logic [7:0] blk,
                                            input logic [7:0] byt);
    return byt[{blk[1:0], 1'b0} +: 2];
  endfunction

  always_comb begin
    st_d = st_q;
    ret_d = ret_q;
    fn_d = fn_q;
    idx_d = idx_q;
    step_d = step_q;
    mac_d = mac_q;
    prot_d = prot_q;
    wr_d = '0;
    cmd_d = cmd_q;
    cmd_d.valid = 1'b0;
    sraddr_d = sraddr_q;
    taddr_d = taddr_q;
    acc_d = acc_q;
    x_d = x_q;
    perm_d = perm_q;
    busy_d = busy_q;
    done_d = 1'b0;
    halt_d = halt_q;
    unique case (st_q)
      S_IDLE: begin
        if (start_i && func_i != FPS_FN_NONE) begin
          fn_d = func_i;
          busy_d = 1'b1;
          idx_d = '0;
          step_d = '0;
          mac_d = 1'(FPS_MACROS - 1);
          cmd_d.divider = divider_i;
          cmd_d.delay = delay_i;
          // Key check; function code not run on bad keys
          if (first_key_slot_i != FPS_FIRST_KEY_SLOT_VALUE || second_key_slot_i != stack_ptr_i) begin
            st_d = S_HALT;
          end else begin
            unique case (func_i)
              FPS_FN_PROTECT: begin
                st_d = S_PROT_RD;
                sraddr_d = FPS_ADDR_PROT_SRC;
              end
              FPS_FN_ERASE_ALL: st_d = S_EA_USER;
              FPS_FN_TABLE_READ: begin
                st_d = S_TBL;
                taddr_d = {block_number_param_i[2:0], 3'h0};
                sraddr_d = FPS_ADDR_FIRST_KEY_SLOT;
              end
              default: st_d = S_CHECK;
            endcase
          end
        end
      end
      // SRAM byte returns one cycle after its address
      S_PROT_RD: st_d = S_PROT_WR;
      S_PROT_WR: begin
        // OR only: protect can never lower a level
        prot_d[idx_q] = prot_q[idx_q] | sram_rdata_i;
        idx_d = idx_q + 7'h1;
        sraddr_d = sraddr_q + 8'h1;
        st_d = (idx_q == 7'(FPS_MACROS*FPS_PROT_BYTES - 1)) ? S_FINISH : S_PROT_RD;
      end
      S_EA_USER: begin
        // User space of both macros is targeted here; the protection blocks follow in S_EA_PROT
        cmd_d = '{1'b1, (step_q == 2'h1) ? FPS_OP_ZERO : FPS_OP_ERASE, mac_q, 1'b0,
                  cmd_q.divider, cmd_q.delay};
        ret_d = S_EA_USER;
        st_d = S_EA_WAIT;
      end
      S_EA_PROT: begin
        cmd_d = '{1'b1, step_q[0] ? FPS_OP_ZERO : FPS_OP_ERASE, mac_q, 1'b1,
                  cmd_q.divider, cmd_q.delay};
        ret_d = S_EA_PROT;
        st_d = S_EA_WAIT;
      end
      S_EA_WAIT: begin
        if (flash_done_i) begin
          st_d = ret_q;
          step_d = step_q + 2'h1;
          if (ret_q == S_EA_USER && step_q == 2'h2) begin
            step_d = '0;
            mac_d = mac_q - 1'b1;
            if (mac_q == '0) begin
              st_d = S_EA_PROT;
              mac_d = 1'(FPS_MACROS - 1);
            end
          end else if (ret_q == S_EA_PROT && step_q == 2'h1) begin
            step_d = '0;
            for (int i = 0; i < FPS_PROT_BYTES; i++) begin
              prot_d[{mac_q, i[5:0]}] = 8'h00;
            end
            mac_d = mac_q - 1'b1;
            if (mac_q == '0) begin
              st_d = S_FINISH;
            end
          end
        end
      end
      S_TBL: begin
        // Eight table bytes land in F8h..FFh
        wr_d = '{1'b1, sraddr_q, table_rdata_i};
        sraddr_d = sraddr_q + 8'h1;
        taddr_d = taddr_q + 6'h1;
        if (taddr_q[2:0] == FPS_TBL_LAST[2:0]) begin
          st_d = S_FINISH;
          if (taddr_q[5:3] == FPS_TBL_TRIM) begin
            acc_d = trim_rev_i;
            x_d = FPS_TRIM_X;
          end else begin
            acc_d = FPS_DIE_REV[7:0];
            x_d = FPS_DIE_REV[15:8];
          end
        end
      end
      S_CHECK: begin
        // Supervisory access only; table-read instruction bypasses this path
        perm_d = level_perm(block_level(block_number_param_i,
                   prot_q[{1'b0, block_number_param_i[7:2]}]));
        acc_d = '0;
        x_d = '0;
        if ((fn_q == FPS_FN_CHECK_READ && !perm_d.supervisor_read_allowed) ||
            (fn_q == FPS_FN_CHECK_WRITE && !perm_d.internal_write_allowed)) begin
          wr_d = '{1'b1, FPS_ADDR_FIRST_KEY_SLOT, FPS_RC_PROTECTED};
        end else begin
          wr_d = '{1'b1, FPS_ADDR_FIRST_KEY_SLOT, FPS_RC_OK};
        end
        st_d = S_FINISH;
      end
      S_FINISH: begin
        busy_d = 1'b0;
        done_d = 1'b1;
        st_d = S_IDLE;
      end
      S_HALT: begin
        halt_d = 1'b1;
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      ret_q <= S_IDLE;
      fn_q <= FPS_FN_NONE;
      idx_q <= '0;
      step_q <= '0;
      mac_q <= '0;
      wr_q <= '0;
      cmd_q <= '0;
      sraddr_q <= '0;
      taddr_q <= '0;
      acc_q <= '0;
      x_q <= '0;
      perm_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ret_q <= ret_d;
      fn_q <= fn_d;
      idx_q <= idx_d;
      step_q <= step_d;
      mac_q <= mac_d;
      wr_q <= wr_d;
      cmd_q <= cmd_d;
      sraddr_q <= sraddr_d;
      taddr_q <= taddr_d;
      acc_q <= acc_d;
      x_q <= x_d;
      perm_q <= perm_d;
      busy_q <= busy_d;
      done_q <= done_d;
      halt_q <= halt_d;
    end
  end

  // Nonvolatile contents: not cleared by reset
  always_ff @(posedge clk_i) begin
    prot_q <= prot_d;
  end

  assign sram_wr_o = wr_q;
  assign sram_raddr_o = sraddr_q;
  assign flash_cmd_o = cmd_q;
  assign table_addr_o = taddr_q;
  assign acc_o = acc_q;
  assign idx_o = x_q;
  assign perm_o = perm_q;
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign halt_o = halt_q;
endmodule

// ---- bench/fps_supervisor_props.sv ----
`timescale 1ns/1ps
module fps_supervisor_chk
  import fps_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic start_i, // Call pulse
  input wire fps_func_t func_i, // Requested function
  input wire logic [7:0] first_key_slot_i, // Key slot one
  input wire logic [7:0] second_key_slot_i, // Key slot two
  input wire logic [7:0] stack_ptr_i, // Stack pointer
  input wire logic [7:0] divider_i, // Pulse divider
  input wire fps_sram_wr_t sram_wr_o, // SRAM write
  input wire fps_flash_cmd_t flash_cmd_o, // Flash command
  input wire fps_perm_t perm_o, // Permissions
  input wire logic busy_o, // Busy
  input wire logic done_o, // Done pulse
  input wire logic halt_o // Halt
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  logic bad;
  fps_func_t fn_q, fn_d;
  logic [7:0] div_q, div_d;
  assign take = start_i && !busy_o && func_i != FPS_FN_NONE;
  assign bad = first_key_slot_i != FPS_FIRST_KEY_SLOT_VALUE || second_key_slot_i != stack_ptr_i;
  always_comb begin
    fn_d = take ? func_i : fn_q;
    div_d = take ? divider_i : div_q;
  end
  always_ff @(posedge clk_i) begin
    fn_q <= fn_d;
    div_q <= div_d;
  end
  take_busy_a: assert property (take |=> busy_o) else $error("call not taken");
  check_time_a: assert property (
    take && !bad && func_i inside {FPS_FN_CHECK_READ, FPS_FN_CHECK_WRITE} |-> ##3 done_o)
    else $error("check latency wrong");
  // Eight table states plus the finish state
  table_time_a: assert property (
    take && !bad && func_i == FPS_FN_TABLE_READ |-> ##10 done_o)
    else $error("table read latency wrong");
  protect_time_a: assert property (
    take && !bad && func_i == FPS_FN_PROTECT |-> ##258 done_o)
    else $error("protect latency wrong");
  done_pulse_a: assert property (done_o |-> !busy_o ##1 !done_o)
    else $error("done not a single pulse");
  bad_key_a: assert property (take && bad |-> ##2 halt_o) else $error("no halt");
  // Reset is the only way out of halt
  halt_hold_a: assert property (halt_o && !rst_i |=> halt_o && busy_o)
    else $error("halt released");
  refuse_code_a: assert property (
    sram_wr_o.we && sram_wr_o.addr == FPS_ADDR_FIRST_KEY_SLOT &&
    fn_q inside {FPS_FN_CHECK_READ, FPS_FN_CHECK_WRITE} |-> sram_wr_o.data ==
    (((fn_q == FPS_FN_CHECK_READ) ? perm_o.supervisor_read_allowed :
    perm_o.internal_write_allowed) ? FPS_RC_OK : FPS_RC_PROTECTED))
    else $error("return code wrong");
  table_dest_a: assert property (
    sram_wr_o.we && fn_q == FPS_FN_TABLE_READ |-> sram_wr_o.addr[7:3] == 5'h1f)
    else $error("table write out of slot");
  flash_div_a: assert property (
    flash_cmd_o.valid |-> flash_cmd_o.divider == div_q ##1 !flash_cmd_o.valid)
    else $error("flash divider wrong");
  cover property (take && func_i == FPS_FN_ERASE_ALL);
  cover property (done_o && fn_q == FPS_FN_PROTECT);
  cover property (halt_o);
endmodule

bind fps_supervisor fps_supervisor_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .start_i(start_i), .func_i(func_i), .first_key_slot_i(first_key_slot_i), .second_key_slot_i(second_key_slot_i),
  .stack_ptr_i(stack_ptr_i), .divider_i(divider_i), .sram_wr_o(sram_wr_o),
  .flash_cmd_o(flash_cmd_o), .perm_o(perm_o), .busy_o(busy_o), .done_o(done_o),
  .halt_o(halt_o));

// ---- bench/fps_supervisor_bench.sv ----
`timescale 1ns/1ps
module fps_supervisor_bench;
  import fps_pkg::*;
  logic clk_i = 0, rst_i = 1, start_i = 0, flash_done_i = 0;
  fps_func_t func_i = FPS_FN_NONE;
  logic [7:0] first_key_slot_i = FPS_FIRST_KEY_SLOT_VALUE, second_key_slot_i = 0, stack_ptr_i = 0, block_number_param_i = 0;
  logic [7:0] divider_i = 0, delay_i = 0, sram_rdata_i = 0, table_rdata_i, trim_rev_i = 0;
  fps_sram_wr_t sram_wr_o;
  fps_flash_cmd_t flash_cmd_o;
  fps_perm_t perm_o;
  logic [5:0] table_addr_o;
  logic [7:0] sram_raddr_o, acc_o, idx_o;
  logic busy_o, done_o, halt_o;
  logic [7:0] mem [256];
  logic [7:0] prot [64];
  fps_sram_wr_t wq[$];
  fps_flash_cmd_t fq[$];
  integer seed = 32'hb58f, err_count = 0, compares = 0, fcnt = 0;
  // Erase-all order as {op, macro, protection block}
  localparam logic [39:0] SEQ = 40'h2620403715;

  fps_supervisor u_dut (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .func_i(func_i),
    .first_key_slot_i(first_key_slot_i), .second_key_slot_i(second_key_slot_i), .stack_ptr_i(stack_ptr_i),
    .block_number_param_i(block_number_param_i), .divider_i(divider_i), .delay_i(delay_i),
    .sram_rdata_i(sram_rdata_i), .flash_done_i(flash_done_i), .table_rdata_i(table_rdata_i),
    .trim_rev_i(trim_rev_i), .sram_wr_o(sram_wr_o), .sram_raddr_o(sram_raddr_o),
    .flash_cmd_o(flash_cmd_o), .table_addr_o(table_addr_o), .acc_o(acc_o), .idx_o(idx_o),
    .perm_o(perm_o), .busy_o(busy_o), .done_o(done_o), .halt_o(halt_o));

  always #10 clk_i = ~clk_i;

  function automatic logic [7:0] tbyte(input logic [5:0] a);
    return {a, 2'h1} ^ 8'ha5;
  endfunction
  assign table_rdata_i = tbyte(table_addr_o);

  // SRAM answers one cycle late; flash completes after a random wait
  always @(posedge clk_i) begin
    sram_rdata_i <= mem[sram_raddr_o];
    flash_done_i <= (fcnt == 1);
    if (fcnt > 0) fcnt <= fcnt - 1;
    if (flash_cmd_o.valid === 1'b1) begin
      fq.push_back(flash_cmd_o);
      fcnt <= 2 + ($random(seed) & 7);
    end
    if (sram_wr_o.we === 1'b1) wq.push_back(sram_wr_o);
  end

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic call(input fps_func_t f, input logic [7:0] b);
    integer n;
    wq.delete();
    @(posedge clk_i);
    start_i <= 1;
    func_i <= f;
    block_number_param_i <= b;
    divider_i <= 8'($random(seed));
    delay_i <= 8'($random(seed));
    @(posedge clk_i);
    start_i <= 0;
    for (n = 0; n < 9000 && done_o !== 1'b1; n++) @(negedge clk_i);
    if (n == 9000) chk("done", 0, 1);
    @(negedge clk_i);
  endtask

  task automatic sweep();
    logic [1:0] lv;
    for (int b = 0; b < 256; b++) begin
      lv = prot[b / 4][2 * (b % 4) +: 2];
      call(FPS_FN_CHECK_READ, 8'(b));
      chk("perm", perm_o, {lv == 0, lv == 0, lv < 2, lv != 3});
      chk("read code", wq[0], {1'b1, FPS_ADDR_FIRST_KEY_SLOT, (lv != 0) ? 8'h01 : 8'h00});
      call(FPS_FN_CHECK_WRITE, 8'(b));
      chk("write code", wq[0], {1'b1, FPS_ADDR_FIRST_KEY_SLOT, (lv == 3) ? 8'h01 : 8'h00});
    end
  endtask

  task automatic erase_all();
    fq.delete();
    call(FPS_FN_ERASE_ALL, 8'h00);
    chk("flash ops", 24'(fq.size()), 10);
    for (int i = 0; i < 10; i++)
      chk("flash op", {fq[i].op, fq[i].macro, fq[i].prot_blk, fq[i].divider, fq[i].delay},
        {SEQ[39 - 4 * i -: 4], divider_i, delay_i});
    foreach (prot[k]) prot[k] = 8'h00;
    sweep();
  endtask

  initial begin
    stack_ptr_i = 8'($random(seed));
    second_key_slot_i = stack_ptr_i;
    trim_rev_i = 8'($random(seed));
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    erase_all();
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 128; k++) mem[128 + k] = 8'($random(seed) & $random(seed));
      mem[128 + p] = 8'hff;
      call(FPS_FN_PROTECT, 8'h00);
      for (int k = 0; k < 64; k++) prot[k] |= mem[128 + k];
      sweep();
    end
    for (int t = 0; t < 8; t++) begin
      call(FPS_FN_TABLE_READ, {5'($random(seed)), 3'(t)});
      chk("table count", 24'(wq.size()), 8);
      for (int i = 0; i < 8; i++)
        chk("table byte", wq[i], {1'b1, 8'hf8 + 8'(i), tbyte(6'(t * 8 + i))});
      if (t == 0) chk("die rev", {idx_o, acc_o}, FPS_DIE_REV);
      if (t == 1) chk("trim rev", {idx_o, acc_o}, {8'hff, trim_rev_i});
    end
    erase_all();
    @(posedge clk_i);
    second_key_slot_i <= second_key_slot_i ^ 8'h01;
    start_i <= 1;
    func_i <= FPS_FN_TABLE_READ;
    @(posedge clk_i);
    start_i <= 0;
    repeat (4) @(negedge clk_i);
    chk("halt", {busy_o, halt_o}, 2'b11);
    @(posedge clk_i);
    rst_i <= 1;
    @(posedge clk_i);
    rst_i <= 0;
    @(negedge clk_i);
    chk("after reset", {busy_o, done_o, halt_o}, 0);
    test_done();
  end

  // Roughly 11k cycles expected; cut off at 75k cycles, well above that
  initial begin
    #1500000;
    err_count++;
    test_done();
  end
endmodule
